/* src/sos_pkg.sv */
/*
  Package of the status output selector: register offsets, field positions,
  reset values, function codes and the state and condition carriers.
  Assumes a 32-bit classic Wishbone slave port on a single clock.
*/
package sos_pkg;

  localparam int SOS_NOUT = 6;  // terminals 11..15 then the relay
  localparam int SOS_FUNC_W = 5;

  // byte offsets
  localparam logic [7:0] SOS_FUNC_BASE = 8'h00;  // one word per output, 0x00..0x14
  localparam logic [7:0] SOS_POL_BASE = 8'h18;   // one word per output, 0x18..0x2C
  localparam logic [7:0] SOS_CTRL_OFS = 8'h30;
  localparam logic [7:0] SOS_STAT_OFS = 8'h34;
  localparam logic [7:0] SOS_COND_OFS = 8'h38;

  // control fields
  localparam int SOS_CTRL_TORQUE_EN_BIT = 0;
  localparam int SOS_CTRL_ACODE_LSB = 1;
  localparam logic [1:0] SOS_ACODE_OFF = 2'h0;
  localparam logic [1:0] SOS_ACODE_3BIT = 2'h1;
  localparam logic [1:0] SOS_ACODE_4BIT = 2'h2;

  // status fields
  localparam int SOS_STAT_PIN_LSB = 0;
  localparam int SOS_STAT_FAULT_BIT = 6;
  localparam int SOS_STAT_ABOVE_BIT = 7;

  // polarity codes
  localparam logic SOS_POL_NO = 1'b0;  // code 00
  localparam logic SOS_POL_NC = 1'b1;  // code 01

  // function codes
  localparam logic [4:0] SOS_F_RUN = 5'h00;
  localparam logic [4:0] SOS_F_AT_SET = 5'h01;
  localparam logic [4:0] SOS_F_ABOVE = 5'h02;
  localparam logic [4:0] SOS_F_OVERLOAD = 5'h03;
  localparam logic [4:0] SOS_F_PID = 5'h04;
  localparam logic [4:0] SOS_F_FAULT = 5'h05;
  localparam logic [4:0] SOS_F_AT_THR = 5'h06;
  localparam logic [4:0] SOS_F_TORQUE = 5'h07;
  localparam logic [4:0] SOS_F_PWR_LOSS = 5'h08;
  localparam logic [4:0] SOS_F_LOW_SUP = 5'h09;
  localparam logic [4:0] SOS_F_TQ_LIMIT = 5'h0A;
  localparam logic [4:0] SOS_F_RUN_TIME = 5'h0B;
  localparam logic [4:0] SOS_F_ON_TIME = 5'h0C;
  localparam logic [4:0] SOS_F_HEAT = 5'h0D;
  localparam logic [4:0] SOS_F_BRAKE_REL = 5'h13;
  localparam logic [4:0] SOS_F_BRAKE_ERR = 5'h14;
  localparam logic [4:0] SOS_F_ZERO = 5'h15;
  localparam logic [4:0] SOS_F_VEL_ERR = 5'h16;

  // reset values
  localparam logic [SOS_NOUT-1:0][4:0] SOS_FUNC_RST = {5'h05, 5'h08, 5'h07, 5'h03, 5'h00, 5'h01};
  localparam logic [SOS_NOUT-1:0] SOS_POL_RST = {SOS_POL_NC, {5{SOS_POL_NO}}};
  localparam logic [2:0] SOS_CTRL_RST = 3'h0;

  // status conditions from the drive core, same clock
  typedef struct packed {
    logic run;
    logic speed_at_setpoint;
    logic accelerating;
    logic decelerating;
    logic freq_ge_accel_level;
    logic freq_lt_decel_level;
    logic freq_eq_accel_level;
    logic freq_eq_decel_level;
    logic overcurrent_warning;
    logic pid_error_exceed;
    logic trip;
    logic fault_reset;
    logic excess_torque;
    logic power_loss_flag;
    logic low_supply_flag;
    logic torque_limiting;
    logic run_time_over;
    logic powered_time_over;
    logic motor_overheat;
    logic brake_release;
    logic brake_in_use;
    logic brake_fault;
    logic speed_zero;
    logic velocity_error_exceed;
  } sos_cond_t;

  typedef struct packed {
    logic [SOS_NOUT-1:0][4:0] func;
    logic [SOS_NOUT-1:0] pol;
    logic [2:0] ctrl;
    logic fault_latched_flag;
    logic speed_above_threshold;
    logic [SOS_NOUT-1:0] pins;
    logic ack;
    logic [31:0] rdata;
  } sos_state_t;

endpackage

/* src/sos_selector.sv */
/*
  Status output selector: routes one status condition to each of five logic
  terminals and the alarm relay, applies per-output polarity and the optional
  alarm code override; registers over a classic Wishbone slave.
  Assumes the condition inputs and alarm code come from logic on i_mclk.
*/
// Local design decisions: the address map and register access over Wishbone.
// Function
// RL1: each output has own polarity, 00/01
// RL2: terminals 11-15 polarity resets to 00
// RL3: relay polarity resets to 01
// RL4: code 00 follows run state
// RL5: code 01 output at set frequency
// RL6: code 02 set accel, clear decel threshold
// RL7: code 03 output current above overload level
// RL8: code 04 PID error above threshold
// RL9: code 05 latched trip until reset
// RL10: code 06 at accel/decel arrival level
// RL11: code 07 excess torque when detection enabled
// RL12: codes 08 and 09 low supply
// RL13: code 10 torque beyond quadrant limit
// RL14: code 11 run time over limit
// RL15: code 12 powered time over limit
// RL16: code 13 motor thermal limit exceeded
// RL17: code 19 brake release command
// RL18: code 20 brake current too low
// RL19: code 21 encoder pulses stopped
// RL20: code 22 velocity error above threshold
// RL21: alarm code replaces terminals 11-13/14
// RL22: function selects reset 01,00,03,07,08,05
// RL23: polarity applied after selection, every clock
// RL24: undefined codes select constant inactive
module sos_selector
  import sos_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire sos_cond_t i_cond,
  input wire logic [3:0] i_alarm_code,
  output logic [4:0] o_term,
  output logic o_relay
);

  sos_state_t st;
  sos_state_t next_st;
  logic [31:0] cond_vec;
  logic [SOS_NOUT-1:0] selected;

  // condition vector indexed by function code; holes stay zero
  always_comb begin
    cond_vec = 32'h0000_0000; // RL24
    cond_vec[SOS_F_RUN] = i_cond.run; // RL4
    cond_vec[SOS_F_AT_SET] = i_cond.speed_at_setpoint; // RL5
    cond_vec[SOS_F_ABOVE] = st.speed_above_threshold; // RL6
    cond_vec[SOS_F_OVERLOAD] = i_cond.overcurrent_warning; // RL7
    cond_vec[SOS_F_PID] = i_cond.pid_error_exceed; // RL8
    cond_vec[SOS_F_FAULT] = st.fault_latched_flag; // RL9
    cond_vec[SOS_F_AT_THR] = (i_cond.accelerating & i_cond.freq_eq_accel_level) |
                             (i_cond.decelerating & i_cond.freq_eq_decel_level); // RL10
    cond_vec[SOS_F_TORQUE] = st.ctrl[SOS_CTRL_TORQUE_EN_BIT] & i_cond.excess_torque; // RL11
    cond_vec[SOS_F_PWR_LOSS] = i_cond.power_loss_flag; // RL12
    cond_vec[SOS_F_LOW_SUP] = i_cond.low_supply_flag; // RL12
    cond_vec[SOS_F_TQ_LIMIT] = i_cond.torque_limiting; // RL13
    cond_vec[SOS_F_RUN_TIME] = i_cond.run_time_over; // RL14
    cond_vec[SOS_F_ON_TIME] = i_cond.powered_time_over; // RL15
    cond_vec[SOS_F_HEAT] = i_cond.motor_overheat; // RL16
    cond_vec[SOS_F_BRAKE_REL] = i_cond.brake_release; // RL17
    cond_vec[SOS_F_BRAKE_ERR] = i_cond.brake_in_use & i_cond.brake_fault; // RL18
    cond_vec[SOS_F_ZERO] = i_cond.speed_zero; // RL19
    cond_vec[SOS_F_VEL_ERR] = i_cond.velocity_error_exceed; // RL20
  end

  always_comb begin
    for (int i = 0; i < SOS_NOUT; i++) begin
      selected[i] = cond_vec[st.func[i]];
    end
    // alarm code bits take over the low terminals
    case (st.ctrl[SOS_CTRL_ACODE_LSB +: 2])
      SOS_ACODE_3BIT: begin
        selected[2:0] = i_alarm_code[2:0]; // RL21
      end
      SOS_ACODE_4BIT: begin
        selected[3:0] = i_alarm_code; // RL21
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    logic req;
    logic wr;
    logic [7:0] ofs;
    req = 1'b0;
    wr = 1'b0;
    ofs = 8'h00;
    next_st = st;
    req = i_wb_cyc & i_wb_stb & ~st.ack;
    wr = req & i_wb_we & i_wb_sel[0];
    ofs = i_wb_adr;

    // hysteresis between the two arrival levels
    if (i_cond.accelerating & i_cond.freq_ge_accel_level) begin
      next_st.speed_above_threshold = 1'b1; // RL6
    end else if (i_cond.decelerating & i_cond.freq_lt_decel_level) begin
      next_st.speed_above_threshold = 1'b0; // RL6
    end

    // a trip in the same cycle as the reset wins
    if (i_cond.trip) begin
      next_st.fault_latched_flag = 1'b1; // RL9
    end else if (i_cond.fault_reset) begin
      next_st.fault_latched_flag = 1'b0; // RL9
    end

    next_st.pins = selected ^ st.pol; // RL23 RL1

    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    if (req) begin
      for (int i = 0; i < SOS_NOUT; i++) begin
        if (ofs == SOS_FUNC_BASE + 8'(4 * i)) begin
          next_st.rdata = {27'h0, st.func[i]};
          if (wr) begin
            next_st.func[i] = i_wb_dat[4:0];
          end
        end
        if (ofs == SOS_POL_BASE + 8'(4 * i)) begin
          next_st.rdata = {31'h0, st.pol[i]};
          if (wr) begin
            next_st.pol[i] = i_wb_dat[0]; // RL1
          end
        end
      end
      if (ofs == SOS_CTRL_OFS) begin
        next_st.rdata = {29'h0, st.ctrl};
        if (wr) begin
          next_st.ctrl = i_wb_dat[2:0];
        end
      end
      if (ofs == SOS_STAT_OFS) begin
        next_st.rdata = 32'h0000_0000;
        next_st.rdata[SOS_STAT_PIN_LSB +: SOS_NOUT] = st.pins;
        next_st.rdata[SOS_STAT_FAULT_BIT] = st.fault_latched_flag;
        next_st.rdata[SOS_STAT_ABOVE_BIT] = st.speed_above_threshold;
      end
      if (ofs == SOS_COND_OFS) begin
        next_st.rdata = cond_vec;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.func <= SOS_FUNC_RST; // RL22
      st.pol <= SOS_POL_RST; // RL2 RL3
      st.ctrl <= SOS_CTRL_RST;
      // pins idle at the inactive level of each polarity
      st.pins <= SOS_POL_RST; // RL23
    end else begin
      st <= next_st;
    end
  end

  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.rdata;
  assign o_term = st.pins[4:0];
  assign o_relay = st.pins[5];

endmodule // sos_selector

/* tb/sos_lamps.sv */
/*
  Lamp and relay coil model on the selector's outputs.
  Assumes open-collector terminals: a pin that is on sinks lamp current.
*/
module sos_lamps (
  input wire logic [4:0] i_term,
  input wire logic i_relay,
  output logic [5:0] o_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_lit = {i_relay, i_term};
endmodule // sos_lamps

/* tb/sos_selector_props.sv */
/*
  Checker of the selector's bus handshake, read widths and pin timing.
  Assumes it is bound to every sos_selector and sees only its ports.
*/
module sos_selector_props
  import sos_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire sos_cond_t i_cond,
  input wire logic [3:0] i_alarm_code,
  input wire logic [4:0] o_term,
  input wire logic o_relay
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_ack_next_cycle: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack missing");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data outside ack");
  a_reset_pin_levels: assert property ($fell(i_rst) |-> o_term == 5'h00 && o_relay) else $error("reset pins");
  // latched codes need two edges, so four quiet samples
  a_pins_hold_stable: assert property ((!(i_wb_cyc && i_wb_we) && $stable(i_cond) && $stable(i_alarm_code))[*4]
    |-> $stable(o_term) && $stable(o_relay)) else $error("pins moved");
  a_pol_one_bit: assert property (o_wb_ack && !i_wb_we && i_wb_adr >= SOS_POL_BASE && i_wb_adr < SOS_CTRL_OFS
    |-> o_wb_dat[31:1] == 31'h0) else $error("polarity width");
  a_func_five_bit: assert property (o_wb_ack && !i_wb_we && i_wb_adr < SOS_POL_BASE
    |-> o_wb_dat[31:5] == 27'h0) else $error("function width");
  a_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr > SOS_COND_OFS
    |-> o_wb_dat == 32'h0) else $error("unmapped data");
endmodule // sos_selector_props

bind sos_selector sos_selector_props u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cond(i_cond), .i_alarm_code(i_alarm_code),
  .o_term(o_term), .o_relay(o_relay));

/* tb/tb_top.sv */
/*
  Testbench of the status output selector: Wishbone tasks and pin checks.
  Assumes sos_selector, the lamp model and the bound checker.
*/
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_top
  import sos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [3:0] acode = 4'h0;
  logic [3:0] sel = 4'hF;
  sos_cond_t cond = '0;
  logic ack, relay;
  logic [4:0] term;
  logic [5:0] lit;
  int fails = 0, n_checks = 0;
  logic [4:0] fr [6] = '{5'h01, 5'h00, 5'h03, 5'h07, 5'h08, 5'h05};
  logic [4:0] fc [16] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
    5'h0D, 5'h13, 5'h14, 5'h15, 5'h16};
  logic [23:0] fm [16] = '{24'h800000, 24'h400000, 24'h008000, 24'h004000, 24'h220000, 24'h000800,
    24'h000400, 24'h000200, 24'h000100, 24'h000080, 24'h000040, 24'h000020, 24'h000010, 24'h00000C,
    24'h000002, 24'h000001};
  sos_selector dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_cond(cond),
    .i_alarm_code(acode), .o_term(term), .o_relay(relay));
  sos_lamps u_lamps (.i_term(term), .i_relay(relay), .o_lit(lit));
  task automatic complete_run();
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // no own limit: a missing ack is left to the watchdog
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge i_mclk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // a latched condition needs two edges to reach a pin, a direct one needs one; three gives margin
  task automatic pin(input logic [23:0] c, input logic e);
    cond <= c;
    repeat (3) @(posedge i_mclk);
    `CHK(lit[0], e)
  endtask
  initial forever #25 i_mclk = ~i_mclk;
  initial begin
    #500us;
    fails++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      wb(1'b0, SOS_FUNC_BASE + 8'(4 * k), 32'h0);
      `CHK(q[4:0], fr[k])
      wb(1'b0, SOS_POL_BASE + 8'(4 * k), 32'h0);
      `CHK(q[0], logic'(k == 5))
    end
    // lane 0 off: write acked but dropped
    sel <= 4'hE;
    wb(1'b1, SOS_CTRL_OFS, 32'h1);
    sel <= 4'hF;
    wb(1'b0, SOS_CTRL_OFS, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, SOS_CTRL_OFS, 32'h1);
    for (int k = 0; k < 16; k++) begin
      wb(1'b1, SOS_FUNC_BASE, 32'(fc[k]));
      pin(fm[k], 1'b1);
      pin(24'h0, 1'b0);
    end
    wb(1'b1, SOS_CTRL_OFS, 32'h0);
    wb(1'b1, SOS_FUNC_BASE, 32'h7);
    pin(24'h000800, 1'b0);
    wb(1'b1, SOS_FUNC_BASE, 32'h2);
    pin(24'h280000, 1'b1);
    pin(24'h0, 1'b1);
    pin(24'h140000, 1'b0);
    wb(1'b1, SOS_FUNC_BASE, 32'h5);
    pin(24'h002000, 1'b1);
    pin(24'h0, 1'b1);
    pin(24'h001000, 1'b0);
    wb(1'b1, SOS_FUNC_BASE, 32'hE);
    pin(24'hFFFFFF, 1'b0);
    wb(1'b1, SOS_POL_BASE, 32'h1);
    pin(24'h0, 1'b1);
    `CHK(lit[5], 1'b0)
    wb(1'b1, SOS_POL_BASE + 8'h14, 32'h0);
    pin(24'h0, 1'b1);
    `CHK(lit[5], 1'b1)
    wb(1'b1, SOS_POL_BASE, 32'h0);
    acode <= 4'hA;
    wb(1'b1, SOS_CTRL_OFS, 32'h4);
    pin(24'h0, 1'b0);
    `CHK(lit[3:0], 4'hA)
    wb(1'b1, SOS_CTRL_OFS, 32'h2);
    pin(24'h0, 1'b0);
    `CHK(lit[3:0], 4'h2)
    wb(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h0)
    // relay carries the latched fault, terminal 12 alarm code bit 1
    wb(1'b0, SOS_STAT_OFS, 32'h0);
    `CHK(q, 32'hE2)
    wb(1'b0, SOS_COND_OFS, 32'h0);
    `CHK(q, 32'h24)
    complete_run();
  end
endmodule // tb_top
